// [hw/uef_endpoint_fifos.sv]
// Purpose: setup buffer and double-sided receive/transmit endpoint buffers
// Assumes: all inputs come from logic on CLOCK_I, so none are synchronised
// Notes:   usb side moves bytes; cpu side moves 8, 16 or 32 bit accesses
`timescale 1ns/1ps
`default_nettype none

`include "uef_map.svh"

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - usb writes to the setup buffer take precedence over cpu reads.
// - new setup arrival cancels a cpu setup read; read value is zero.
// - at most 64 bytes are read from the current receive side.
// - read-done trigger switches receive side and shows that side's count.
// - packet-ready trigger switches transmit side for the next packet.
// - double-sided data registers take 8, 16 or 32 bit accesses.
module uef_endpoint_fifos
	import uef_pkg::*;
#(
	parameter int MAX_PKT = `UEF_MAX_PKT,
	parameter int TXQ_DEPTH = `UEF_TXQ_DEPTH
) (
	input  wire logic        CLOCK_I,
	input  wire logic        RST_I,
	input  wire logic        SETUP_START_I,
	input  wire logic        SETUP_WR_I,
	input  wire logic [7:0]  SETUP_WDATA_I,
	input  wire logic        SETUP_RD_I,
	output logic      [7:0]  SETUP_RDATA_O,
	output logic             SETUP_RVALID_O,
	output logic             SETUP_RD_CANCEL_O,
	output logic             SETUP_VALID_O,
	input  wire logic        OUT_WR_I,
	input  wire logic [7:0]  OUT_WDATA_I,
	input  wire logic        OUT_PKT_END_I,
	input  wire logic        OUT_CLEAR_I,
	input  wire logic        OUT_RD_I,
	input  wire logic [1:0]  OUT_RD_SIZE_I,
	input  wire logic        OUT_READ_DONE_I,
	output logic      [31:0] OUT_RDATA_O,
	output logic             OUT_RVALID_O,
	output logic             OUT_RD_BUSY_O,
	output logic      [6:0]  OUT_RX_SIZE_O,
	output logic             OUT_SIDE_O,
	output logic             OUT_BUF_AVAIL_O,
	input  wire logic        IN_WR_I,
	input  wire logic [1:0]  IN_WR_SIZE_I,
	input  wire logic [31:0] IN_WDATA_I,
	input  wire logic        IN_PKT_READY_I,
	output logic             IN_WR_READY_O,
	input  wire logic        IN_CLEAR_I,
	input  wire logic        IN_RD_I,
	output logic      [7:0]  IN_RDATA_O,
	output logic             IN_RVALID_O,
	input  wire logic        IN_TX_DONE_I,
	output logic      [6:0]  IN_TX_SIZE_O,
	output logic             IN_SIDE_O,
	output logic             IN_PKT_AVAIL_O
);

	if (MAX_PKT < 1 || MAX_PKT > `UEF_MAX_PKT)
	begin : g_bad_pkt
		$error("uef_endpoint_fifos: MAX_PKT must lie in 1..64");
	end

	localparam logic [6:0] PKT_LIM = 7'(MAX_PKT);
	localparam logic [6:0] RD_LIM  = 7'(`UEF_MAX_PKT);

	// byte lanes minus one for an access size code
	function automatic logic [1:0] last_lane(input uef_size_t sz);
		logic [1:0] r;
		r = 2'h3;
		if (sz == `UEF_SIZE_BYTE)
			r = 2'h0;
		else if (sz == `UEF_SIZE_HALF)
			r = 2'h1;
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// setup buffer on the control endpoint

	logic [7:0] setup_q [`UEF_SETUP_BYTES];
	logic [`UEF_SETUP_IDX_W-1:0] setup_widx_q;
	logic [`UEF_SETUP_IDX_W-1:0] setup_ridx_q;
	logic                        setup_busy_q;
	logic                        setup_usb_act;

	// any usb activity on the buffer blocks the cpu this cycle
	assign setup_usb_act = SETUP_START_I | SETUP_WR_I | setup_busy_q;

	always_ff @(posedge CLOCK_I)
	begin
		if (SETUP_WR_I)
			setup_q[setup_widx_q] <= SETUP_WDATA_I;
	end

	// reception progress: start pulse, then eight byte writes
	always_ff @(posedge CLOCK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			setup_widx_q  <= '0;
			setup_busy_q  <= 1'b0;
			SETUP_VALID_O <= 1'b0;
		end
		else if (SETUP_START_I)
		begin
			setup_widx_q  <= '0;
			setup_busy_q  <= 1'b1;
			SETUP_VALID_O <= 1'b0;
		end
		else if (SETUP_WR_I)
		begin
			setup_widx_q <= setup_widx_q + 1'b1;
			if (setup_widx_q == 3'h7)
			begin
				setup_busy_q  <= 1'b0;
				SETUP_VALID_O <= 1'b1;
			end
		end
	end

	// cpu read: one byte a request; read index is not rewound by a new
	// setup, so a read left half done misaligns the next command
	always_ff @(posedge CLOCK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			setup_ridx_q      <= '0;
			SETUP_RDATA_O     <= 8'h00;
			SETUP_RVALID_O    <= 1'b0;
			SETUP_RD_CANCEL_O <= 1'b0;
		end
		else
		begin
			SETUP_RVALID_O    <= 1'b0;
			SETUP_RD_CANCEL_O <= 1'b0;
			if (SETUP_RD_I && setup_usb_act)
			begin
				SETUP_RDATA_O     <= 8'h00;
				SETUP_RD_CANCEL_O <= 1'b1;
			end
			else if (SETUP_RD_I)
			begin
				SETUP_RDATA_O  <= setup_q[setup_ridx_q];
				SETUP_RVALID_O <= 1'b1;
				setup_ridx_q   <= setup_ridx_q + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// receive endpoint: usb fills one side, cpu drains the other

	logic       rx_full_q [2];
	logic [6:0] rx_cnt_q  [2];
	logic       rx_ws_q;
	logic [6:0] rx_wptr_q;
	logic [6:0] rx_rptr_q;
	logic [6:0] rx_avail;
	logic       rx_wen;
	logic       rx_ren;
	logic [7:0] rx_rbyte;
	uef_rd_e    rd_st_q;
	logic [1:0] rd_lane_q;
	logic [1:0] rd_last_q;
	logic       rd_hit_q;

	// readable bytes on the current side, never above one pass
	assign rx_avail = rx_full_q[OUT_SIDE_O] ? ((rx_cnt_q[OUT_SIDE_O] > RD_LIM) ?
		RD_LIM : rx_cnt_q[OUT_SIDE_O]) : 7'h00;
	assign rx_wen   = OUT_WR_I && !rx_full_q[rx_ws_q] && (rx_wptr_q < PKT_LIM);
	assign rx_ren   = (rd_st_q == RD_ADDR);

	uef_mem #(
		.WIDTH (8),
		.DEPTH (`UEF_SIDE_BYTES)
	) u_rx_mem (
		.clk_i     (CLOCK_I),
		.rst_i     (RST_I),
		.wr_en_i   (rx_wen),
		.wr_addr_i ({rx_ws_q, rx_wptr_q[`UEF_PTR_W-1:0]}),
		.wr_data_i (OUT_WDATA_I),
		.rd_en_i   (rx_ren),
		.rd_addr_i ({OUT_SIDE_O, rx_rptr_q[`UEF_PTR_W-1:0]}),
		.rd_data_o (rx_rbyte)
	);

	// side bookkeeping; a side seal wins over a read-done release
	always_ff @(posedge CLOCK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			rx_full_q  <= '{default: 1'b0};
			rx_cnt_q   <= '{default: 7'h00};
			rx_ws_q    <= 1'b0;
			rx_wptr_q  <= 7'h00;
			OUT_SIDE_O <= 1'b0;
		end
		else if (OUT_CLEAR_I)
		begin
			rx_full_q  <= '{default: 1'b0};
			rx_cnt_q   <= '{default: 7'h00};
			rx_ws_q    <= 1'b0;
			rx_wptr_q  <= 7'h00;
			OUT_SIDE_O <= 1'b0;
		end
		else
		begin
			if (rx_wen)
				rx_wptr_q <= rx_wptr_q + 7'h01;
			if (OUT_READ_DONE_I)
			begin
				rx_full_q[OUT_SIDE_O] <= 1'b0;
				OUT_SIDE_O            <= ~OUT_SIDE_O;
			end
			if (OUT_PKT_END_I && !rx_full_q[rx_ws_q])
			begin
				rx_full_q[rx_ws_q] <= 1'b1;
				rx_cnt_q[rx_ws_q]  <= rx_wptr_q;
				rx_ws_q            <= ~rx_ws_q;
				rx_wptr_q          <= 7'h00;
			end
		end
	end

	// size seen by the cpu follows the current side one cycle later
	always_ff @(posedge CLOCK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			OUT_RX_SIZE_O   <= 7'h00;
			OUT_BUF_AVAIL_O <= 1'b0;
		end
		else
		begin
			OUT_RX_SIZE_O   <= rx_full_q[OUT_SIDE_O] ? rx_cnt_q[OUT_SIDE_O] : 7'h00;
			OUT_BUF_AVAIL_O <= !rx_full_q[rx_ws_q];
		end
	end

	// cpu read sequencer: two cycles per byte, lanes fill from bit 0 up;
	// bytes past the valid count come back as zero and do not advance
	always_ff @(posedge CLOCK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			rd_st_q       <= RD_IDLE;
			rd_lane_q     <= 2'h0;
			rd_last_q     <= 2'h0;
			rd_hit_q      <= 1'b0;
			rx_rptr_q     <= 7'h00;
			OUT_RDATA_O   <= 32'h0000_0000;
			OUT_RVALID_O  <= 1'b0;
			OUT_RD_BUSY_O <= 1'b0;
		end
		else if (OUT_CLEAR_I || OUT_READ_DONE_I)
		begin
			rd_st_q       <= RD_IDLE;
			rx_rptr_q     <= 7'h00;
			OUT_RVALID_O  <= 1'b0;
			OUT_RD_BUSY_O <= 1'b0;
		end
		else
		begin
			OUT_RVALID_O <= 1'b0;
			case (rd_st_q)
				RD_IDLE:
				begin
					if (OUT_RD_I)
					begin
						rd_last_q     <= last_lane(OUT_RD_SIZE_I);
						rd_lane_q     <= 2'h0;
						OUT_RDATA_O   <= 32'h0000_0000;
						OUT_RD_BUSY_O <= 1'b1;
						rd_st_q       <= RD_ADDR;
					end
				end
				RD_ADDR:
				begin
					rd_hit_q <= (rx_rptr_q < rx_avail);
					rd_st_q  <= RD_DATA;
				end
				RD_DATA:
				begin
					if (rd_hit_q)
					begin
						OUT_RDATA_O[{rd_lane_q, 3'b000} +: 8] <= rx_rbyte;
						rx_rptr_q <= rx_rptr_q + 7'h01;
					end
					rd_lane_q <= rd_lane_q + 2'h1;
					if (rd_lane_q == rd_last_q)
					begin
						OUT_RVALID_O  <= 1'b1;
						OUT_RD_BUSY_O <= 1'b0;
						rd_st_q       <= RD_IDLE;
					end
					else
						rd_st_q <= RD_ADDR;
				end
				default:
					rd_st_q <= RD_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// transmit endpoint: cpu queue -> fill side, usb drains the other

	uef_word_s  txq_in;
	uef_word_s  txq_out;
	uef_word_s  tx_word_q;
	logic       txq_valid;
	logic       txq_pop;
	logic       tx_full_q [2];
	logic [6:0] tx_cnt_q  [2];
	logic       tx_ws_q;
	logic [6:0] tx_wptr_q;
	logic [6:0] tx_rptr_q;
	logic       tx_wen;
	logic       tx_seal;
	uef_wr_e    wr_st_q;
	logic [1:0] wr_lane_q;

	// a write and a packet-ready in one cycle travel as one entry
	assign txq_in  = '{wr: IN_WR_I, seal: IN_PKT_READY_I, size: IN_WR_SIZE_I,
		data: IN_WDATA_I};
	// stall draining while the fill side still waits for the host
	assign txq_pop = (wr_st_q == WR_IDLE) && txq_valid && !tx_full_q[tx_ws_q];
	assign tx_wen  = (wr_st_q == WR_BYTE) && (tx_wptr_q < PKT_LIM);
	assign tx_seal = (wr_st_q == WR_SEAL);

	uef_fifo #(
		.WIDTH ($bits(uef_word_s)),
		.DEPTH (TXQ_DEPTH)
	) u_txq (
		.clk_i       (CLOCK_I),
		.rst_i       (RST_I),
		.flush_i     (IN_CLEAR_I),
		.in_valid_i  (IN_WR_I | IN_PKT_READY_I),
		.in_data_i   (txq_in),
		.in_ready_o  (IN_WR_READY_O),
		.out_valid_o (txq_valid),
		.out_data_o  (txq_out),
		.out_ready_i (txq_pop)
	);

	uef_mem #(
		.WIDTH (8),
		.DEPTH (`UEF_SIDE_BYTES)
	) u_tx_mem (
		.clk_i     (CLOCK_I),
		.rst_i     (RST_I),
		.wr_en_i   (tx_wen),
		.wr_addr_i ({tx_ws_q, tx_wptr_q[`UEF_PTR_W-1:0]}),
		.wr_data_i (tx_word_q.data[{wr_lane_q, 3'b000} +: 8]),
		.rd_en_i   (IN_RD_I),
		.rd_addr_i ({IN_SIDE_O, tx_rptr_q[`UEF_PTR_W-1:0]}),
		.rd_data_o (IN_RDATA_O)
	);

	// drain sequencer: one byte a cycle into the fill side
	always_ff @(posedge CLOCK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			wr_st_q   <= WR_IDLE;
			wr_lane_q <= 2'h0;
			tx_word_q <= '0;
		end
		else if (IN_CLEAR_I)
			wr_st_q <= WR_IDLE;
		else
		begin
			case (wr_st_q)
				WR_IDLE:
				begin
					if (txq_pop)
					begin
						tx_word_q <= txq_out;
						wr_lane_q <= 2'h0;
						wr_st_q   <= txq_out.wr ? WR_BYTE : WR_SEAL;
					end
				end
				WR_BYTE:
				begin
					wr_lane_q <= wr_lane_q + 2'h1;
					if (wr_lane_q == last_lane(tx_word_q.size))
						wr_st_q <= tx_word_q.seal ? WR_SEAL : WR_IDLE;
				end
				WR_SEAL:
					wr_st_q <= WR_IDLE;
				default:
					wr_st_q <= WR_IDLE;
			endcase
		end
	end

	// side bookkeeping; a seal wins over a transmit-done release
	always_ff @(posedge CLOCK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			tx_full_q <= '{default: 1'b0};
			tx_cnt_q  <= '{default: 7'h00};
			tx_ws_q   <= 1'b0;
			tx_wptr_q <= 7'h00;
			tx_rptr_q <= 7'h00;
			IN_SIDE_O <= 1'b0;
		end
		else if (IN_CLEAR_I)
		begin
			tx_full_q <= '{default: 1'b0};
			tx_cnt_q  <= '{default: 7'h00};
			tx_ws_q   <= 1'b0;
			tx_wptr_q <= 7'h00;
			tx_rptr_q <= 7'h00;
			IN_SIDE_O <= 1'b0;
		end
		else
		begin
			if (tx_wen)
				tx_wptr_q <= tx_wptr_q + 7'h01;
			if (IN_RD_I && tx_rptr_q < tx_cnt_q[IN_SIDE_O])
				tx_rptr_q <= tx_rptr_q + 7'h01;
			if (IN_TX_DONE_I)
			begin
				tx_full_q[IN_SIDE_O] <= 1'b0;
				IN_SIDE_O            <= ~IN_SIDE_O;
				tx_rptr_q            <= 7'h00;
			end
			if (tx_seal)
			begin
				tx_full_q[tx_ws_q] <= 1'b1;
				tx_cnt_q[tx_ws_q]  <= tx_wptr_q;
				tx_ws_q            <= ~tx_ws_q;
				tx_wptr_q          <= 7'h00;
			end
		end
	end

	// usb-facing status, registered
	always_ff @(posedge CLOCK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			IN_RVALID_O    <= 1'b0;
			IN_TX_SIZE_O   <= 7'h00;
			IN_PKT_AVAIL_O <= 1'b0;
		end
		else
		begin
			IN_RVALID_O    <= IN_RD_I;
			IN_TX_SIZE_O   <= tx_full_q[IN_SIDE_O] ? tx_cnt_q[IN_SIDE_O] : 7'h00;
			IN_PKT_AVAIL_O <= tx_full_q[IN_SIDE_O];
		end
	end

endmodule

`default_nettype wire

// [hw/uef_map.svh]
// Purpose: constants of the endpoint buffering block
// Assumes: included by the package and by the design files
// Notes:   counts are in bytes unless named otherwise
`ifndef UEF_MAP_SVH
`define UEF_MAP_SVH

// setup buffer on the control endpoint
`define UEF_SETUP_BYTES 8
`define UEF_SETUP_IDX_W 3

// double-sided endpoint sides
`define UEF_MAX_PKT     64
`define UEF_CNT_W       7
`define UEF_PTR_W       6
`define UEF_SIDE_BYTES  128

// cpu access size codes
`define UEF_SIZE_BYTE   2'h0
`define UEF_SIZE_HALF   2'h1
`define UEF_SIZE_WORD   2'h2

// depth of the cpu-to-transmit queue
`define UEF_TXQ_DEPTH   4

`endif

// [hw/uef_pkg.sv]
// Purpose: types shared by the endpoint buffering block
// Assumes: uef_map.svh holds the numbers
// Notes:   one-hot state codes are written out
`include "uef_map.svh"

package uef_pkg;

	typedef logic [1:0] uef_size_t;

	// one cpu transmit entry: data write and/or packet-ready marker
	typedef struct packed {
		logic      wr;
		logic      seal;
		uef_size_t size;
		logic [31:0] data;
	} uef_word_s;

	typedef enum logic [2:0] {
		RD_IDLE = 3'b001,
		RD_ADDR = 3'b010,
		RD_DATA = 3'b100
	} uef_rd_e;

	typedef enum logic [2:0] {
		WR_IDLE = 3'b001,
		WR_BYTE = 3'b010,
		WR_SEAL = 3'b100
	} uef_wr_e;

endpackage

// [hw/uef_mem.sv]
// Purpose: byte memory holding both sides of one endpoint
// Assumes: one write port, one read port, same clock
// Notes:   read data come out of a register one cycle after rd_en_i
`timescale 1ns/1ps
`default_nettype none

module uef_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 128
) (
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	input  wire logic                     wr_en_i,
	input  wire logic [$clog2(DEPTH)-1:0] wr_addr_i,
	input  wire logic [WIDTH-1:0]         wr_data_i,
	input  wire logic                     rd_en_i,
	input  wire logic [$clog2(DEPTH)-1:0] rd_addr_i,
	output logic      [WIDTH-1:0]         rd_data_o
);

	if (DEPTH < 2 || WIDTH < 1)
	begin : g_bad_cfg
		$error("uef_mem: DEPTH must be at least 2 and WIDTH at least 1");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];

	// storage has no reset: contents are only meaningful once written
	always_ff @(posedge clk_i)
	begin
		if (wr_en_i)
			mem_q[wr_addr_i] <= wr_data_i;
	end

	// registered read port
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			rd_data_o <= '0;
		else if (rd_en_i)
			rd_data_o <= mem_q[rd_addr_i];
	end

endmodule

`default_nettype wire

// [hw/uef_fifo.sv]
// Purpose: small synchronous valid/ready queue
// Assumes: DEPTH a power of two, single clock
// Notes:   in_ready_o is registered so the source sees a clean stall
`timescale 1ns/1ps
`default_nettype none

module uef_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             flush_i,
	input  wire logic             in_valid_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  in_ready_o,
	output logic                  out_valid_o,
	output logic      [WIDTH-1:0] out_data_o,
	input  wire logic             out_ready_i
);

	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH)
	begin : g_bad_cfg
		$error("uef_fifo: DEPTH must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] buf_q [DEPTH];
	logic [AW-1:0]    wptr_q;
	logic [AW-1:0]    rptr_q;
	logic [AW:0]      cnt_q;
	logic [AW:0]      cnt_d;
	logic             push;
	logic             pop;

	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;
	assign out_valid_o = (cnt_q != '0);
	assign out_data_o  = buf_q[rptr_q];

	always_comb
	begin
		cnt_d = cnt_q;
		if (push && !pop)
			cnt_d = cnt_q + 1'b1;
		else if (pop && !push)
			cnt_d = cnt_q - 1'b1;
	end

	// entries
	always_ff @(posedge clk_i)
	begin
		if (push)
			buf_q[wptr_q] <= in_data_i;
	end

	// pointers, fill level and the registered ready
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			wptr_q     <= '0;
			rptr_q     <= '0;
			cnt_q      <= '0;
			in_ready_o <= 1'b0;
		end
		else if (flush_i)
		begin
			wptr_q     <= '0;
			rptr_q     <= '0;
			cnt_q      <= '0;
			in_ready_o <= 1'b1;
		end
		else
		begin
			if (push)
				wptr_q <= wptr_q + 1'b1;
			if (pop)
				rptr_q <= rptr_q + 1'b1;
			cnt_q      <= cnt_d;
			in_ready_o <= (cnt_d != (AW+1)'(DEPTH));
		end
	end

endmodule

`default_nettype wire

// [bench/uef_fifo_properties.sv]
// Purpose: port-level checks of the endpoint buffering block
// Assumes: one clock, RST_I asynchronous and active high
// Notes:   bound to every uef_endpoint_fifos instance
`timescale 1ns/1ps
`default_nettype none

module uef_fifo_properties #(
	parameter int MAX_PKT = 64
) (
	input wire logic       CLOCK_I,
	input wire logic       RST_I,
	input wire logic       SETUP_START_I,
	input wire logic       SETUP_WR_I,
	input wire logic       SETUP_RD_I,
	input wire logic       SETUP_RVALID_O,
	input wire logic       SETUP_RD_CANCEL_O,
	input wire logic       SETUP_VALID_O,
	input wire logic       OUT_CLEAR_I,
	input wire logic       OUT_RD_I,
	input wire logic [1:0] OUT_RD_SIZE_I,
	input wire logic       OUT_READ_DONE_I,
	input wire logic       OUT_RVALID_O,
	input wire logic       OUT_RD_BUSY_O,
	input wire logic [6:0] OUT_RX_SIZE_O,
	input wire logic       OUT_SIDE_O,
	input wire logic       IN_CLEAR_I,
	input wire logic       IN_TX_DONE_I,
	input wire logic [6:0] IN_TX_SIZE_O,
	input wire logic       IN_SIDE_O
);
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (RST_I);

	////////////////////////////////////////////////////////////////////////////////
	// receive read steps: a taken request, then cycles free of abort
	sequence s_take(sz);
		OUT_RD_I && !OUT_RD_BUSY_O && OUT_RD_SIZE_I == sz && !OUT_READ_DONE_I && !OUT_CLEAR_I;
	endsequence
	sequence s_quiet;
		!OUT_READ_DONE_I && !OUT_CLEAR_I;
	endsequence

	property p_setup_cancel;
		SETUP_RD_I && (SETUP_START_I || SETUP_WR_I) |=> SETUP_RD_CANCEL_O && !SETUP_RVALID_O;
	endproperty
	a_setup_cancel: assert property (p_setup_cancel) else $error("setup read not refused");
	property p_setup_answer;
		SETUP_RD_I |=> SETUP_RVALID_O != SETUP_RD_CANCEL_O;
	endproperty
	a_setup_answer: assert property (p_setup_answer) else $error("setup read answer wrong");
	property p_setup_restart;
		SETUP_START_I |=> !SETUP_VALID_O;
	endproperty
	a_setup_restart: assert property (p_setup_restart) else $error("setup valid kept");
	// byte read answers in 3 cycles, word read in 9
	property p_rd_byte;
		s_take(2'h0) ##1 s_quiet [*2] |=> OUT_RVALID_O;
	endproperty
	a_rd_byte: assert property (p_rd_byte) else $error("byte read late");
	property p_rd_word;
		s_take(2'h2) ##1 s_quiet [*8] |=> OUT_RVALID_O;
	endproperty
	a_rd_word: assert property (p_rd_word) else $error("word read late");
	property p_rx_cap;
		OUT_RX_SIZE_O <= MAX_PKT;
	endproperty
	a_rx_cap: assert property (p_rx_cap) else $error("receive size above cap");
	property p_tx_cap;
		IN_TX_SIZE_O <= MAX_PKT;
	endproperty
	a_tx_cap: assert property (p_tx_cap) else $error("transmit size above cap");
	property p_out_flip;
		OUT_READ_DONE_I && !OUT_CLEAR_I |=> OUT_SIDE_O != $past(OUT_SIDE_O);
	endproperty
	a_out_flip: assert property (p_out_flip) else $error("receive side kept");
	property p_in_flip;
		IN_TX_DONE_I && !IN_CLEAR_I |=> IN_SIDE_O != $past(IN_SIDE_O);
	endproperty
	a_in_flip: assert property (p_in_flip) else $error("transmit side kept");
endmodule

bind uef_endpoint_fifos uef_fifo_properties #(.MAX_PKT(MAX_PKT)) u_props (.*);
`default_nettype wire

// [bench/uef_host_model.sv]
// Purpose: usb host side of the endpoint buffers, byte by byte
// Assumes: driven from tasks, changes just after rising edges
// Notes:   a released data line shows the inverse of its last byte, except after a gapped setup command, which ends on the byte itself
`timescale 1ns/1ps
`default_nettype none

module uef_host_model (
	input  wire logic       clk_i,
	output logic            setup_start_o,
	output logic            setup_wr_o,
	output logic      [7:0] setup_wdata_o,
	output logic            out_wr_o,
	output logic      [7:0] out_wdata_o,
	output logic            out_pkt_end_o,
	output logic            in_rd_o,
	output logic            in_tx_done_o,
	input  wire logic [7:0] in_rdata_i,
	input  wire logic       in_rvalid_i
);
	logic [7:0] got [0:7];

	// idle link at time zero
	initial
	begin
		{setup_start_o, setup_wr_o, out_wr_o, out_pkt_end_o, in_rd_o, in_tx_done_o} = 6'h00;
		setup_wdata_o = 8'h00;
		out_wdata_o = 8'h00;
	end

	////////////////////////////////////////////////////////////////////////////////
	// start plus eight setup bytes; gap idles slow the host down
	task automatic setup_cmd(input logic [7:0] base, input int gap);
		@(posedge clk_i);
		setup_start_o <= 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clk_i);
			setup_start_o <= 1'b0;
			setup_wr_o <= 1'b1;
			setup_wdata_o <= base + i[7:0];
			if (gap > 0)
			begin
				@(posedge clk_i);
				setup_wr_o <= 1'b0;
				setup_wdata_o <= ~setup_wdata_o;
				repeat (gap - 1) @(posedge clk_i);
			end
		end
		@(posedge clk_i);
		setup_wr_o <= 1'b0;
		setup_wdata_o <= ~setup_wdata_o;
	endtask

	// back-to-back receive bytes, then the seal
	task automatic rx_pkt(input logic [7:0] base, input int n);
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk_i);
			out_wr_o <= 1'b1;
			out_wdata_o <= base + i[7:0];
		end
		@(posedge clk_i);
		out_wr_o <= 1'b0;
		out_wdata_o <= ~out_wdata_o;
		out_pkt_end_o <= 1'b1;
		@(posedge clk_i);
		out_pkt_end_o <= 1'b0;
	endtask

	// slow reads; a byte without its valid pulse is kept as unknown
	task automatic tx_read(input int n);
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk_i);
			in_rd_o <= 1'b1;
			@(posedge clk_i);
			in_rd_o <= 1'b0;
			#1;
			got[i] = in_rvalid_i ? in_rdata_i : 8'hXX;
		end
	endtask

	task automatic tx_done();
		@(posedge clk_i);
		in_tx_done_o <= 1'b1;
		@(posedge clk_i);
		in_tx_done_o <= 1'b0;
	endtask
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// Purpose: self-checking bench of the endpoint buffering block
// Assumes: host model on the usb side, bench tasks on the cpu side
// Notes:   triggers go out as one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
`include "uef_map.svh"

module tb_top;
	logic        CLOCK_I, RST_I, SETUP_RD_I, OUT_RD_I, IN_WR_I, IN_PKT_READY_I;
	logic [1:0]  OUT_RD_SIZE_I, IN_WR_SIZE_I;
	logic [31:0] IN_WDATA_I;
	logic [2:0]  trg;
	wire logic   OUT_READ_DONE_I = trg[0];
	wire logic   OUT_CLEAR_I = trg[1];
	wire logic   IN_CLEAR_I = trg[2];
	wire logic   SETUP_START_I, SETUP_WR_I, OUT_WR_I, OUT_PKT_END_I, IN_RD_I, IN_TX_DONE_I;
	wire logic   SETUP_RVALID_O, SETUP_RD_CANCEL_O, SETUP_VALID_O, OUT_RVALID_O;
	wire logic   OUT_RD_BUSY_O, OUT_SIDE_O, OUT_BUF_AVAIL_O, IN_WR_READY_O;
	wire logic   IN_RVALID_O, IN_SIDE_O, IN_PKT_AVAIL_O;
	wire logic [7:0]  SETUP_WDATA_I, OUT_WDATA_I, SETUP_RDATA_O, IN_RDATA_O;
	wire logic [6:0]  OUT_RX_SIZE_O, IN_TX_SIZE_O;
	wire logic [31:0] OUT_RDATA_O;
	int          fails = 0;
	int          checked = 0;

	uef_endpoint_fifos DUT (.*);

	uef_host_model host (.clk_i(CLOCK_I), .setup_start_o(SETUP_START_I),
		.setup_wr_o(SETUP_WR_I), .setup_wdata_o(SETUP_WDATA_I), .out_wr_o(OUT_WR_I),
		.out_wdata_o(OUT_WDATA_I), .out_pkt_end_o(OUT_PKT_END_I), .in_rd_o(IN_RD_I),
		.in_tx_done_o(IN_TX_DONE_I), .in_rdata_i(IN_RDATA_O), .in_rvalid_i(IN_RVALID_O));

	// 50 MHz clock
	initial
	begin
		CLOCK_I = 1'b0;
		forever #10 CLOCK_I = ~CLOCK_I;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic pulse(input logic [2:0] m);
		@(posedge CLOCK_I);
		trg <= m;
		@(posedge CLOCK_I);
		trg <= 3'h0;
	endtask

	// status comes back as {cancel, valid}
	task automatic setup_rd(output logic [1:0] st, output logic [7:0] d);
		@(posedge CLOCK_I);
		SETUP_RD_I <= 1'b1;
		@(posedge CLOCK_I);
		SETUP_RD_I <= 1'b0;
		#1;
		st = {SETUP_RD_CANCEL_O, SETUP_RVALID_O};
		d = SETUP_RDATA_O;
	endtask

	// whole eight-byte unit, so the next command stays aligned
	task automatic rd8(input logic [7:0] base);
		logic [1:0] st;
		logic [7:0] d;
		for (int i = 0; i < 8; i++)
		begin
			setup_rd(st, d);
			chk("setup read", {st, d}, {2'b01, base + i[7:0]});
		end
	endtask

	// waits for the answer under a bound; next request only after it
	task automatic rx_rd(input logic [1:0] sz, output logic [31:0] d);
		@(posedge CLOCK_I);
		OUT_RD_I <= 1'b1;
		OUT_RD_SIZE_I <= sz;
		@(posedge CLOCK_I);
		OUT_RD_I <= 1'b0;
		#1;
		chk("rx busy", OUT_RD_BUSY_O, 32'h1);
		for (int n = 0; n < 20 && OUT_RVALID_O !== 1'b1; n++)
			@(posedge CLOCK_I) #1;
		d = OUT_RDATA_O;
	endtask

	// held until ready is seen high at an edge
	task automatic in_push(input logic wr, input logic seal, input logic [1:0] sz,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge CLOCK_I);
		IN_WR_I <= wr;
		IN_PKT_READY_I <= seal;
		IN_WR_SIZE_I <= sz;
		IN_WDATA_I <= d;
		do
			@(posedge CLOCK_I);
		while (IN_WR_READY_O !== 1'b1 && ++n < 50);
		IN_WR_I <= 1'b0;
		IN_PKT_READY_I <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_setup();
		logic [1:0] st;
		logic [7:0] d;
		host.setup_cmd(8'h10, 0);
		repeat (2) @(posedge CLOCK_I);
		chk("setup valid", SETUP_VALID_O, 32'h1);
		rd8(8'h10);
		// reads while a slow command arrives hit both byte and idle cycles
		fork
			host.setup_cmd(8'h20, 2);
			begin
				repeat (3) @(posedge CLOCK_I);
				repeat (3)
				begin
					setup_rd(st, d);
					chk("setup cancel", st, 32'h2);
				end
			end
		join
		rd8(8'h20);
		$display("t_setup done");
	endtask

	task automatic t_rx();
		logic [31:0] d;
		host.rx_pkt(8'h40, 5);
		host.rx_pkt(8'h50, 3);
		repeat (2) @(posedge CLOCK_I);
		chk("rx size", OUT_RX_SIZE_O, 32'h5);
		rx_rd(`UEF_SIZE_WORD, d);
		chk("rx word", d, 32'h43424140);
		rx_rd(`UEF_SIZE_BYTE, d);
		chk("rx byte", d, 32'h44);
		rx_rd(`UEF_SIZE_HALF, d);
		chk("rx over", d, 32'h0);
		pulse(3'h1);
		repeat (2) @(posedge CLOCK_I);
		chk("rx side", {OUT_SIDE_O, OUT_RX_SIZE_O}, 32'h83);
		rx_rd(`UEF_SIZE_HALF, d);
		chk("rx half", d, 32'h5150);
		pulse(3'h1);
		host.rx_pkt(8'h00, 70);
		repeat (2) @(posedge CLOCK_I);
		chk("rx cap", OUT_RX_SIZE_O, 32'h40);
		for (int i = 0; i < 17; i++)
		begin
			rx_rd(`UEF_SIZE_WORD, d);
			chk("rx full", d, i < 16 ? {8'(4*i+3), 8'(4*i+2), 8'(4*i+1), 8'(4*i)} : 0);
		end
		pulse(3'h2); // link idle at this point
		repeat (2) @(posedge CLOCK_I);
		chk("rx clear", {OUT_BUF_AVAIL_O, OUT_RX_SIZE_O}, 32'h80);
		$display("t_rx done");
	endtask

	task automatic t_tx();
		int n;
		n = 0;
		in_push(1'b1, 1'b0, `UEF_SIZE_WORD, 32'h03020100);
		in_push(1'b1, 1'b0, `UEF_SIZE_HALF, 32'h00000504);
		in_push(1'b0, 1'b1, `UEF_SIZE_BYTE, 32'h0); // seal before the other side
		in_push(1'b1, 1'b1, `UEF_SIZE_BYTE, 32'h000000B0);
		// both seals still queued: the queue fills until it refuses
		@(posedge CLOCK_I);
		IN_WR_I <= 1'b1;
		IN_WDATA_I <= 32'h000000C0;
		do
		begin
			@(posedge CLOCK_I);
			n++;
		end while (IN_WR_READY_O === 1'b1 && n < 8);
		IN_WR_I <= 1'b0;
		chk("tx refuse", n < 8, 32'h1);
		// the first seal lands as the queue fills; the second, queued, lands a few cycles later
		repeat (4) @(posedge CLOCK_I);
		chk("tx size", {IN_PKT_AVAIL_O, IN_TX_SIZE_O}, 32'h86);
		host.tx_read(6);
		for (int i = 0; i < 6; i++)
			chk("tx data", host.got[i], i);
		host.tx_done();
		repeat (2) @(posedge CLOCK_I);
		chk("tx side", {IN_SIDE_O, IN_TX_SIZE_O}, 32'h81);
		host.tx_read(1);
		chk("tx byte", host.got[0], 32'hB0);
		host.tx_done();
		pulse(3'h4);
		repeat (2) @(posedge CLOCK_I);
		chk("tx clear", {IN_WR_READY_O, IN_PKT_AVAIL_O}, 32'h2);
		$display("t_tx done");
	endtask

	task automatic print_verdict();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// hang guard: about twenty times the expected run
	initial
	begin
		#200000;
		fails++;
		print_verdict();
	end

	initial
	begin
		RST_I = 1'b1;
		{SETUP_RD_I, OUT_RD_I, IN_WR_I, IN_PKT_READY_I} = 4'h0;
		{OUT_RD_SIZE_I, IN_WR_SIZE_I, trg} = 7'h00;
		IN_WDATA_I = 32'h0;
		repeat (12) @(posedge CLOCK_I);
		RST_I <= 1'b0;
		repeat (2) @(posedge CLOCK_I);
		t_setup();
		t_rx();
		t_tx();
		print_verdict();
	end
endmodule
`default_nettype wire
